//--- include/fase_pkg.sv
package fase_pkg;
   localparam int SYN_W = 25;
   localparam logic [5:0] FSC_ADDR_SIZE = 6'h00;
   localparam logic [5:0] FSC_TRANSLATION = 6'h04;
   localparam logic [5:0] FSC_ACCESS_FLAG = 6'h08;
   localparam logic [5:0] FSC_PERMISSION = 6'h0C;
   localparam logic [5:0] FSC_EXT_ABORT = 6'h10;
   localparam logic [5:0] FSC_EXT_WALK_LM1 = 6'h11;
   localparam logic [5:0] FSC_EXT_WALK_L0 = 6'h14;
   localparam int SET_LO = 11;
   localparam int FNV_BIT = 10;
   localparam int EA_BIT = 9;
   localparam int S1W_BIT = 7;
   localparam logic [1:0] ERR_RECOVERABLE = 2'h0;
   localparam logic [1:0] ERR_RESERVED = 2'h1;
   localparam logic [1:0] ERR_UNCONTAINABLE = 2'h2;
   localparam logic [1:0] ERR_RESTARTABLE = 2'h3;
   localparam logic [5:0] EC_SYSREG = 6'h18;
   localparam logic [5:0] EC_FETCH_ABORT = 6'h20;
   localparam logic [5:0] EC_IMPL_MONITOR = 6'h1F;
   localparam logic [2:0] LVL_MINUS1 = 3'h7;
   localparam logic [7:0] REG_FETCH_SYN = 8'h00;
   localparam logic [7:0] REG_IMPL_SYN = 8'h04;
   localparam logic [7:0] REG_MON_TRAP = 8'h08;
   localparam logic [7:0] REG_FINE_RD = 8'h0C;
   localparam logic [7:0] REG_FINE_WR = 8'h10;
   localparam logic [7:0] REG_HYP_CACHE = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [24:0] RST_SYN = 25'h000_0000;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam int MT_FINE_EN = 11;
   localparam int HYP_CACHE_BITS = 9;
   typedef enum logic [2:0] {
      FK_ADDR_SIZE = 3'h0,
      FK_TRANSLATION = 3'h1,
      FK_ACCESS_FLAG = 3'h2,
      FK_PERMISSION = 3'h3,
      FK_EXT_ABORT = 3'h4,
      FK_EXT_WALK = 3'h5
   } fase_fault_type;
   typedef enum logic [3:0] {
      GRP_PTR_AUTH = 4'h0,
      GRP_SEC_TIMER = 4'h1,
      GRP_RAS_ERR = 4'h2,
      GRP_FAULT_INJ = 4'h3,
      GRP_ACCESS_CTRL = 4'h4,
      GRP_TRACE = 4'h5,
      GRP_TRACE_FILT = 4'h6,
      GRP_DEBUG = 4'h7,
      GRP_PDN_DEBUG = 4'h8,
      GRP_PERF = 4'h9,
      GRP_ACT_MON = 4'hA,
      GRP_FINE_REGS = 4'hB,
      GRP_CACHE_CTL = 4'hC,
      GRP_OTHER = 4'hD
   } fase_group_type;
   localparam logic [1:0] PL_OS = 2'h1;
   localparam logic [1:0] PL_HYP = 2'h2;
   localparam logic [1:0] PL_MON = 2'h3;
endpackage

//--- hw/fase_fsc_enc.sv
`timescale 1ns/1ps
module fase_fsc_enc #(
   parameter bit LPA2_PRESENT = 1'b0
) (
   // Fault description.
   input wire fase_pkg::fase_fault_type kind_i,
   input wire logic [2:0] level_i,
   // Encoded status.
   output logic [5:0] code_o,
   output logic legal_o,
   output logic external_o
);
   import fase_pkg::*;

   wire [5:0] lvl6 = {4'h0, level_i[1:0]};
   wire lvl_std = ~level_i[2];
   wire lvl_zero = (level_i == 3'h0);
   wire lvl_pos = lvl_std & ~lvl_zero;
   wire lvl_m1 = (level_i == LVL_MINUS1);
   wire [5:0] walk_code;
   wire [5:0] table_code;
   wire lvl0_ok;

   // Walk external aborts: level -1 has its own code, others count up from level 0.
   assign walk_code = lvl_m1 ? FSC_EXT_WALK_LM1 : FSC_EXT_WALK_L0 + lvl6;
   assign table_code = (kind_i == FK_ADDR_SIZE) ? FSC_ADDR_SIZE + lvl6 :
      (kind_i == FK_TRANSLATION) ? FSC_TRANSLATION + lvl6 :
      (kind_i == FK_ACCESS_FLAG) ? FSC_ACCESS_FLAG + lvl6 :
      FSC_PERMISSION + lvl6;
   assign code_o = (kind_i == FK_EXT_ABORT) ? FSC_EXT_ABORT :
      (kind_i == FK_EXT_WALK) ? walk_code : table_code;

   // Level 0 access flag and permission codes exist only with large addresses.
   assign lvl0_ok = lvl_pos | (lvl_zero & LPA2_PRESENT);
   assign legal_o = (kind_i == FK_ADDR_SIZE) ? lvl_std :
      (kind_i == FK_TRANSLATION) ? lvl_std :
      (kind_i == FK_ACCESS_FLAG) ? lvl0_ok :
      (kind_i == FK_PERMISSION) ? lvl0_ok :
      (kind_i == FK_EXT_ABORT) ? 1'b1 :
      (kind_i == FK_EXT_WALK) ? (lvl_std | (lvl_m1 & LPA2_PRESENT)) :
      1'b0;
   assign external_o = (kind_i == FK_EXT_ABORT) | (kind_i == FK_EXT_WALK);
endmodule

//--- hw/fase_top.sv
`timescale 1ns/1ps
module fase_top #(
   parameter bit RAS_PRESENT = 1'b1,
   parameter bit LPA2_PRESENT = 1'b0,
   parameter bit FGT_PRESENT = 1'b1,
   parameter bit EVT_PRESENT = 1'b1
) (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Fetch abort report.
   input wire logic abort_valid_i,
   input wire fase_pkg::fase_fault_type fault_kind_i,
   input wire logic [2:0] fault_level_i,
   input wire logic [1:0] err_state_i,
   input wire logic far_invalid_i,
   input wire logic ext_abort_class_i,
   input wire logic stage2_fault_i,
   input wire logic stage1_walk_i,
   // Own exception to the monitor level.
   input wire logic impl_exc_i,
   input wire logic [24:0] impl_syndrome_i,
   // System register access check.
   input wire logic sr_valid_i,
   input wire fase_pkg::fase_group_type sr_group_i,
   input wire logic [1:0] sr_level_i,
   input wire logic sr_read_i,
   input wire logic [4:0] sr_index_i,
   // Exception outputs.
   output logic [24:0] syndrome_o,
   output logic [5:0] exception_class_o,
   output logic syndrome_valid_o,
   output logic abort_illegal_o,
   output logic trap_monitor_o,
   output logic trap_hyp_o
);
   import fase_pkg::*;

   logic [24:0] fetch_syn_r;
   logic [24:0] impl_syn_r;
   logic [24:0] syn_out_r;
   logic [11:0] mon_trap_r;
   logic [31:0] fine_rd_r;
   logic [31:0] fine_wr_r;
   logic [8:0] hyp_cache_r;
   logic [5:0] ec_r;
   logic [31:0] rdata_r;
   logic valid_r;
   logic illegal_r;
   logic trap_mon_r;
   logic trap_hyp_r;

   wire [5:0] fsc_code;
   wire fsc_legal;
   wire fsc_external;

   fase_fsc_enc #(
      .LPA2_PRESENT(LPA2_PRESENT)
   ) u_fsc (
      .kind_i(fault_kind_i),
      .level_i(fault_level_i),
      .code_o(fsc_code),
      .legal_o(fsc_legal),
      .external_o(fsc_external)
   );

   // Maps the reported error state, folding the reserved pattern onto uncontainable.
   function automatic logic [1:0] err_map(input logic [1:0] st);
      err_map = (st == ERR_RESERVED) ? ERR_UNCONTAINABLE : st;
   endfunction

   wire capture = abort_valid_i & fsc_legal;
   wire is_sea = (fsc_code == FSC_EXT_ABORT);
   wire [1:0] set_val = (RAS_PRESENT && is_sea) ?
      err_map(err_state_i) : 2'h0;
   wire fnv_val = is_sea & far_invalid_i;
   wire ea_val = fsc_external & ext_abort_class_i;
   wire s1w_val = stage2_fault_i & stage1_walk_i;
   // Reserved bits are forced low whatever the inputs carry.
   wire [24:0] abort_syn = {12'h000, set_val, fnv_val, ea_val, 1'b0, s1w_val, 1'b0,
      fsc_code};

   // Trap decision for system register accesses.
   wire [15:0] mon_bits = {4'h0, mon_trap_r};
   wire below_mon = (sr_level_i != PL_MON);
   wire lower_lvl = (sr_level_i <= PL_OS);
   wire grp_ctl = (sr_group_i <= GRP_ACT_MON);
   wire mon_ctl_hit = grp_ctl & mon_bits[sr_group_i];
   wire fine_mon = FGT_PRESENT && (sr_group_i == GRP_FINE_REGS) && (sr_level_i == PL_HYP)
      && !mon_trap_r[MT_FINE_EN];
   wire trap_mon = sr_valid_i & below_mon & (mon_ctl_hit | fine_mon);
   wire fine_bit = sr_read_i ? fine_rd_r[sr_index_i] : fine_wr_r[sr_index_i];
   wire fine_hit = FGT_PRESENT && lower_lvl && fine_bit;
   wire [15:0] cache_bits = {7'h00, hyp_cache_r};
   wire cache_hit = EVT_PRESENT && (sr_group_i == GRP_CACHE_CTL) && lower_lvl
      && cache_bits[sr_index_i[3:0]];
   wire trap_hyp = sr_valid_i & ~trap_mon & (fine_hit | cache_hit);
   wire trap_any = trap_mon | trap_hyp;

   // Register write decode.
   wire wr_fetch = reg_wr_i & (reg_addr_i == REG_FETCH_SYN);
   wire wr_impl = reg_wr_i & (reg_addr_i == REG_IMPL_SYN);
   wire wr_mon = reg_wr_i & (reg_addr_i == REG_MON_TRAP);
   wire wr_frd = reg_wr_i & (reg_addr_i == REG_FINE_RD);
   wire wr_fwr = reg_wr_i & (reg_addr_i == REG_FINE_WR);
   wire wr_cache = reg_wr_i & (reg_addr_i == REG_HYP_CACHE);

   wire [31:0] status_word = {22'h00_0000, trap_hyp_r, trap_mon_r, 2'h0, ec_r};
   wire [31:0] rd_mux = (reg_addr_i == REG_FETCH_SYN) ? {7'h00, fetch_syn_r} :
      (reg_addr_i == REG_IMPL_SYN) ? {7'h00, impl_syn_r} :
      (reg_addr_i == REG_MON_TRAP) ? {20'h0_0000, mon_trap_r} :
      (reg_addr_i == REG_FINE_RD) ? fine_rd_r :
      (reg_addr_i == REG_FINE_WR) ? fine_wr_r :
      (reg_addr_i == REG_HYP_CACHE) ? {23'h00_0000, hyp_cache_r} :
      (reg_addr_i == REG_STATUS) ? status_word :
      32'h0000_0000;

   // Hardware capture wins over a software write in the same cycle.
   wire [24:0] fetch_nxt = capture ? abort_syn : (wr_fetch ? reg_wdata_i[24:0] : fetch_syn_r);
   wire [24:0] impl_nxt = impl_exc_i ? impl_syndrome_i :
      (wr_impl ? reg_wdata_i[24:0] : impl_syn_r);
   wire [24:0] out_nxt = capture ? abort_syn : (impl_exc_i ? impl_syndrome_i : syn_out_r);
   wire [5:0] ec_nxt = capture ? EC_FETCH_ABORT : impl_exc_i ? EC_IMPL_MONITOR :
      trap_any ? EC_SYSREG : ec_r;

   // Syndrome storage; the cleared value after reset is one allowed choice.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fetch_syn_r <= RST_SYN;
         impl_syn_r <= RST_SYN;
         syn_out_r <= RST_SYN;
         ec_r <= 6'h00;
      end
      else
      begin
         fetch_syn_r <= fetch_nxt;
         impl_syn_r <= impl_nxt;
         syn_out_r <= out_nxt;
         ec_r <= ec_nxt;
      end
   end

   // Trap control registers.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mon_trap_r <= RST_CTRL[11:0];
         fine_rd_r <= RST_CTRL;
         fine_wr_r <= RST_CTRL;
         hyp_cache_r <= RST_CTRL[8:0];
      end
      else
      begin
         if (wr_mon)
            mon_trap_r <= reg_wdata_i[11:0];
         if (wr_frd)
            fine_rd_r <= reg_wdata_i;
         if (wr_fwr)
            fine_wr_r <= reg_wdata_i;
         if (wr_cache)
            hyp_cache_r <= reg_wdata_i[8:0];
      end
   end

   // Event flags and read data.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         valid_r <= 1'b0;
         illegal_r <= 1'b0;
         trap_mon_r <= 1'b0;
         trap_hyp_r <= 1'b0;
         rdata_r <= RST_CTRL;
      end
      else
      begin
         valid_r <= capture | impl_exc_i;
         illegal_r <= abort_valid_i & ~fsc_legal;
         trap_mon_r <= trap_mon;
         trap_hyp_r <= trap_hyp;
         rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign syndrome_o = syn_out_r;
   assign exception_class_o = ec_r;
   assign syndrome_valid_o = valid_r;
   assign abort_illegal_o = illegal_r;
   assign trap_monitor_o = trap_mon_r;
   assign trap_hyp_o = trap_hyp_r;

   // Checks on the syndrome and trap outputs.
   property p_set_only_sea;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && (fsc_code != FSC_EXT_ABORT) |=> syndrome_o[12:11] == 2'h0;
   endproperty
   a_set_only_sea: assert property (p_set_only_sea)
      else $error("Error kind set for a non external abort.");

   property p_set_no_ras;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && !RAS_PRESENT |=> syndrome_o[12:11] == 2'h0;
   endproperty
   a_set_no_ras: assert property (p_set_no_ras)
      else $error("Error kind set without the reliability feature.");

   property p_set_not_reserved;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture |=> syndrome_valid_o && (syndrome_o[12:11] != ERR_RESERVED);
   endproperty
   a_set_not_reserved: assert property (p_set_not_reserved)
      else $error("Reserved error kind produced.");

   property p_set_value;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && RAS_PRESENT && is_sea && (err_state_i == ERR_RESTARTABLE)
      |=> syndrome_o[12:11] == ERR_RESTARTABLE;
   endproperty
   a_set_value: assert property (p_set_value)
      else $error("Error kind not copied for an external abort.");

   property p_fnv_zero;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && !is_sea |=> !syndrome_o[FNV_BIT];
   endproperty
   a_fnv_zero: assert property (p_fnv_zero)
      else $error("Address invalid bit set for another fault code.");

   property p_fnv_copy;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && is_sea |=> syndrome_o[FNV_BIT] == $past(far_invalid_i);
   endproperty
   a_fnv_copy: assert property (p_fnv_copy)
      else $error("Address invalid bit does not follow its cause.");

   property p_ea_zero;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && !fsc_external |=> !syndrome_o[EA_BIT];
   endproperty
   a_ea_zero: assert property (p_ea_zero)
      else $error("External abort type set for a non external abort.");

   property p_s1w;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture |=> syndrome_o[S1W_BIT] == ($past(stage2_fault_i) && $past(stage1_walk_i));
   endproperty
   a_s1w: assert property (p_s1w)
      else $error("Stage 2 walk bit wrong.");

   property p_reserved;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture |=> (syndrome_o[24:13] == 12'h000) && !syndrome_o[8] && !syndrome_o[6]
         && (exception_class_o == EC_FETCH_ABORT);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved syndrome bit set on a fetch abort.");

   property p_fsc;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && (fault_kind_i == FK_TRANSLATION) && (fault_level_i == 3'h2)
      |=> syndrome_o[5:0] == 6'h06;
   endproperty
   a_fsc: assert property (p_fsc)
      else $error("Translation fault code wrong.");

   property p_trap_mon;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      sr_valid_i && below_mon && (sr_group_i == GRP_PTR_AUTH) && mon_trap_r[0]
      |=> trap_monitor_o && !trap_hyp_o && (exception_class_o == EC_SYSREG);
   endproperty
   a_trap_mon: assert property (p_trap_mon)
      else $error("Monitor trap missing.");

   property p_trap_hyp;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      trap_hyp_o |-> $past(sr_valid_i) && ($past(sr_level_i) <= PL_OS);
   endproperty
   a_trap_hyp: assert property (p_trap_hyp)
      else $error("Hypervisor trap from a wrong level.");

   property p_ea_copy;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && fsc_external |=> syndrome_o[EA_BIT] == $past(ext_abort_class_i);
   endproperty
   a_ea_copy: assert property (p_ea_copy)
      else $error("External abort type does not follow its input.");

   property p_illegal;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      abort_valid_i && !fsc_legal && !impl_exc_i |=> abort_illegal_o && !syndrome_valid_o;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("Unencodable fetch abort was captured.");

   property p_sea_code;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && (fault_kind_i == FK_EXT_ABORT) |=> syndrome_o[5:0] == FSC_EXT_ABORT;
   endproperty
   a_sea_code: assert property (p_sea_code)
      else $error("External abort code wrong.");

   property p_walk_code;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && (fault_kind_i == FK_EXT_WALK) && (fault_level_i == 3'h0)
      |=> syndrome_o[5:0] == FSC_EXT_WALK_L0;
   endproperty
   a_walk_code: assert property (p_walk_code)
      else $error("Walk external abort code wrong.");

   property p_addr_code;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      capture && (fault_kind_i == FK_ADDR_SIZE) && (fault_level_i == 3'h3)
      |=> syndrome_o[5:0] == 6'h03;
   endproperty
   a_addr_code: assert property (p_addr_code)
      else $error("Address size fault code wrong.");

   property p_mon_no_trap;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      sr_valid_i && (sr_level_i == PL_MON) |=> !trap_monitor_o && !trap_hyp_o;
   endproperty
   a_mon_no_trap: assert property (p_mon_no_trap)
      else $error("Monitor level access was trapped.");

   property p_impl_syn;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      impl_exc_i && !capture
      |=> (syndrome_o == $past(impl_syndrome_i)) && (exception_class_o == EC_IMPL_MONITOR);
   endproperty
   a_impl_syn: assert property (p_impl_syn)
      else $error("Own monitor syndrome not reported.");

   property p_cache_hyp;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      sr_valid_i && (sr_group_i == GRP_CACHE_CTL) && (sr_level_i <= PL_OS) && !trap_mon
      && cache_bits[sr_index_i[3:0]] |=> trap_hyp_o == EVT_PRESENT;
   endproperty
   a_cache_hyp: assert property (p_cache_hyp)
      else $error("Cache control trap wrong.");

   c_sea: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) capture && is_sea);
   c_impl: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) impl_exc_i);
   c_mon: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) trap_monitor_o);
   c_hyp: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) trap_hyp_o);
endmodule

//--- tb/fase_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) check_eq((got) === (exp), msg)
module fase_top_tb_top;
   import fase_pkg::*;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic av = 1'h0;
   fase_fault_type kind = FK_ADDR_SIZE;
   logic [2:0] lvl = 3'h0;
   logic [1:0] err = 2'h0;
   logic fault_address_invalid = 1'h0;
   logic cls = 1'h0;
   logic s2 = 1'h0;
   logic s1w = 1'h0;
   logic ie = 1'h0;
   logic [24:0] isyn = 25'h000_0000;
   logic sv = 1'h0;
   fase_group_type grp = GRP_OTHER;
   logic [1:0] slvl = 2'h0;
   logic srd = 1'h0;
   logic [4:0] sidx = 5'h00;
   logic [24:0] syn;
   logic [5:0] ec;
   logic svalid;
   logic ill;
   logic tmon;
   logic thyp;
   logic [24:0] syn_b;
   logic svalid_b;
   logic ill_b;
   int n_mismatch = 0;
   int compares = 0;

   fase_top fase_top_i (
      .sys_clk_i(clk), .rst_b_i(rst_b),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata),
      .abort_valid_i(av), .fault_kind_i(kind), .fault_level_i(lvl), .err_state_i(err),
      .far_invalid_i(fault_address_invalid), .ext_abort_class_i(cls), .stage2_fault_i(s2),
      .stage1_walk_i(s1w), .impl_exc_i(ie), .impl_syndrome_i(isyn),
      .sr_valid_i(sv), .sr_group_i(grp), .sr_level_i(slvl), .sr_read_i(srd),
      .sr_index_i(sidx), .syndrome_o(syn), .exception_class_o(ec),
      .syndrome_valid_o(svalid), .abort_illegal_o(ill), .trap_monitor_o(tmon),
      .trap_hyp_o(thyp)
   );

   // Second build: no reliability feature, large addresses present.
   if (1'b1)
   begin : g_alt
      fase_top #(
         .RAS_PRESENT(1'b0),
         .LPA2_PRESENT(1'b1)
      ) fase_top_i (
         .sys_clk_i(clk), .rst_b_i(rst_b),
         .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
         .reg_rdata_o(),
         .abort_valid_i(av), .fault_kind_i(kind), .fault_level_i(lvl), .err_state_i(err),
         .far_invalid_i(fault_address_invalid), .ext_abort_class_i(cls), .stage2_fault_i(s2),
         .stage1_walk_i(s1w), .impl_exc_i(ie), .impl_syndrome_i(isyn),
         .sr_valid_i(sv), .sr_group_i(grp), .sr_level_i(slvl), .sr_read_i(srd),
         .sr_index_i(sidx), .syndrome_o(syn_b), .exception_class_o(),
         .syndrome_valid_o(svalid_b), .abort_illegal_o(ill_b), .trap_monitor_o(),
         .trap_hyp_o()
      );
   end

   always #2 clk = ~clk;

   task complete_run();
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task check_eq(input bit ok, input string msg);
      compares++;
      if (!ok)
      begin
         $display("[FAIL] %0t %s", $time, msg);
         n_mismatch++;
      end
   endtask

   function automatic logic [24:0] fa(input logic [5:0] code, input logic [1:0] s,
                                      input logic f, input logic a, input logic w);
      return {12'h000, s, f, a, 1'h0, w, 1'h0, code};
   endfunction

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   task rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      `CHK(rdata & m, e, "register read data");
   endtask

   task abort(input fase_fault_type k, input logic [2:0] l, input logic [1:0] e,
              input logic f, input logic c, input logic s, input logic w,
              input logic [24:0] x, input bit ok);
      @(posedge clk);
      av <= 1'h1;
      kind <= k;
      lvl <= l;
      err <= e;
      fault_address_invalid <= f;
      cls <= c;
      s2 <= s;
      s1w <= w;
      @(posedge clk);
      av <= 1'h0;
      #1;
      `CHK(svalid, ok, "capture pulse");
      `CHK(ill, !ok, "illegal pulse");
      if (ok)
      begin
         `CHK(syn, x, "fetch abort syndrome");
         `CHK(ec, EC_FETCH_ABORT, "fetch abort class");
      end
   endtask

   task sr_chk(input fase_group_type g, input logic [1:0] l, input logic r,
               input logic [4:0] i, input bit m, input bit h);
      @(posedge clk);
      sv <= 1'h1;
      grp <= g;
      slvl <= l;
      srd <= r;
      sidx <= i;
      @(posedge clk);
      sv <= 1'h0;
      #1;
      `CHK(tmon, m, "monitor trap pulse");
      `CHK(thyp, h, "hypervisor trap pulse");
      if (m | h)
         `CHK(ec, EC_SYSREG, "trap class");
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      for (int a = 0; a <= 24; a += 4)
         rd_reg(8'(a), 32'h0000_0000, 32'hFFFF_FFFF);
      wr_reg(8'h20, 32'hFFFF_FFFF);
      rd_reg(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
      wr_reg(REG_FETCH_SYN, 32'hFFFF_FFFF);
      rd_reg(REG_FETCH_SYN, 32'h01FF_FFFF, 32'hFFFF_FFFF);
      wr_reg(REG_MON_TRAP, 32'hFFFF_FFFF);
      rd_reg(REG_MON_TRAP, 32'h0000_0FFF, 32'hFFFF_FFFF);
      wr_reg(REG_HYP_CACHE, 32'hFFFF_FFFF);
      rd_reg(REG_HYP_CACHE, 32'h0000_01FF, 32'hFFFF_FFFF);
      wr_reg(REG_HYP_CACHE, 32'h0000_0000);
      $display("test register_map done");
      for (int k = 0; k < 4; k++)
         for (int l = 0; l < 4; l++)
            if (!(k >= 2 && l == 0))
               abort(fase_fault_type'(k), 3'(l), 2'h3, 1'h1, 1'h1, 1'(l >> 1), 1'h1,
                     fa(6'(4 * k + l), 2'h0, 1'h0, 1'h0, 1'(l >> 1)),
                     1'b1);
      abort(FK_ACCESS_FLAG, 3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 25'h000_0000,
            1'b0);
      `CHK(svalid_b, 1'h1, "level 0 access flag with large addresses");
      `CHK(syn_b, fa(6'h08, 2'h0, 1'h0, 1'h0, 1'h0), "level 0 access flag code");
      abort(FK_PERMISSION, 3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 25'h000_0000,
            1'b0);
      `CHK(syn_b, fa(6'h0C, 2'h0, 1'h0, 1'h0, 1'h0), "level 0 permission code");
      abort(FK_EXT_WALK, LVL_MINUS1, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 25'h000_0000,
            1'b0);
      `CHK(syn_b, fa(6'h11, 2'h0, 1'h0, 1'h0, 1'h0), "level -1 walk abort code");
      abort(FK_TRANSLATION, 3'h4, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 25'h000_0000, 1'b0);
      `CHK(ill_b, 1'h1, "level above 3 refused in both builds");
      for (int e = 0; e < 4; e++)
      begin
         abort(FK_EXT_ABORT, 3'h0, 2'(e), 1'(e), 1'(e >> 1), 1'h0, 1'h1,
               fa(6'h10, (e == 1) ? 2'h2 : 2'(e), 1'(e), 1'(e >> 1), 1'h0),
               1'b1);
         `CHK(syn_b, fa(6'h10, 2'h0, 1'(e), 1'(e >> 1), 1'h0), "no error kind");
      end
      abort(FK_EXT_WALK, 3'h0, 2'h3, 1'h1, 1'h1, 1'h1, 1'h1,
            fa(6'h14, 2'h0, 1'h0, 1'h1, 1'h1), 1'b1);
      rd_reg(REG_FETCH_SYN, {7'h00, fa(6'h14, 2'h0, 1'h0, 1'h1, 1'h1)},
             32'hFFFF_FFFF);
      $display("test fetch_abort_codes done");
      @(posedge clk);
      ie <= 1'h1;
      isyn <= 25'h1AB_CDEF;
      @(posedge clk);
      ie <= 1'h0;
      #1;
      `CHK(svalid, 1'h1, "own exception pulse");
      `CHK(syn, 25'h1AB_CDEF, "own syndrome");
      `CHK(ec, EC_IMPL_MONITOR, "own exception class");
      rd_reg(REG_IMPL_SYN, 32'h01AB_CDEF, 32'hFFFF_FFFF);
      @(posedge clk);
      ie <= 1'h1;
      av <= 1'h1;
      kind <= FK_EXT_ABORT;
      err <= 2'h0;
      fault_address_invalid <= 1'h0;
      cls <= 1'h0;
      s2 <= 1'h0;
      @(posedge clk);
      ie <= 1'h0;
      av <= 1'h0;
      #1;
      `CHK(syn, fa(6'h10, 2'h0, 1'h0, 1'h0, 1'h0), "abort beats own exception");
      `CHK(ec, EC_FETCH_ABORT, "abort class wins");
      $display("test own_exception done");
      for (int g = 0; g <= 10; g++)
      begin
         wr_reg(REG_MON_TRAP, 32'h0000_0001 << g);
         sr_chk(fase_group_type'(g), PL_OS, 1'h1, 5'h00, 1'b1,
                1'b0);
         sr_chk(fase_group_type'(g), PL_MON, 1'h1, 5'h00, 1'b0, 1'b0);
         sr_chk(fase_group_type'((g + 1) % 11), PL_OS, 1'h0, 5'h00, 1'b0, 1'b0);
      end
      rd_reg(REG_STATUS, {26'h000_0000, EC_SYSREG}, 32'h0000_003F);
      wr_reg(REG_MON_TRAP, 32'h0000_0000);
      sr_chk(GRP_FINE_REGS, PL_HYP, 1'h1, 5'h00, 1'b1, 1'b0);
      wr_reg(REG_MON_TRAP, 32'h0000_0800);
      sr_chk(GRP_FINE_REGS, PL_HYP, 1'h1, 5'h00, 1'b0, 1'b0);
      wr_reg(REG_FINE_RD, 32'h0000_0020);
      sr_chk(GRP_OTHER, PL_OS, 1'h1, 5'h05, 1'b0, 1'b1);
      sr_chk(GRP_OTHER, PL_OS, 1'h0, 5'h05, 1'b0, 1'b0);
      sr_chk(GRP_OTHER, PL_OS, 1'h1, 5'h04, 1'b0, 1'b0);
      wr_reg(REG_FINE_WR, 32'h8000_0000);
      sr_chk(GRP_OTHER, 2'h0, 1'h0, 5'h1F, 1'b0, 1'b1);
      sr_chk(GRP_OTHER, PL_HYP, 1'h0, 5'h1F, 1'b0, 1'b0);
      wr_reg(REG_MON_TRAP, 32'h0000_0801);
      sr_chk(GRP_PTR_AUTH, PL_OS, 1'h1, 5'h05, 1'b1, 1'b0);
      wr_reg(REG_FINE_RD, 32'h0000_0000);
      wr_reg(REG_FINE_WR, 32'h0000_0000);
      wr_reg(REG_HYP_CACHE, 32'h0000_0004);
      sr_chk(GRP_CACHE_CTL, 2'h0, 1'h1, 5'h02, 1'b0, 1'b1);
      sr_chk(GRP_CACHE_CTL, PL_OS, 1'h0, 5'h03, 1'b0, 1'b0);
      $display("test system_register_traps done");
      @(posedge clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      #1;
      `CHK(syn, RST_SYN, "syndrome after second reset");
      rd_reg(REG_MON_TRAP, 32'h0000_0000, 32'hFFFF_FFFF);
      $display("test second_reset done");
      complete_run();
   end

   initial
   begin
      #20000;
      $display("[FAIL] %0t watchdog expired", $time);
      n_mismatch++;
      complete_run();
   end
endmodule
